// *** design/ctpo_cfg.svh ***
// Purpose: constants for the channel scan and time-proportional output block
// Assumes: 25 MHz ref_clk, word-addressed remote buffer memory
// Notes: periods in 0.1 s or 1 s units per the unit select
`ifndef CTPO_CFG_SVH
`define CTPO_CFG_SVH
`define CTPO_ADDR_SAMPLE_SEL 12'h001
`define CTPO_SAMPLE_SEL_BIT 12
`define CTPO_ADDR_UNIT_SEL 12'h002
`define CTPO_ADDR_HC_SEL 12'h003
`define CTPO_ADDR_PERIOD_CH1 12'h10c
`define CTPO_ADDR_PERIOD_CH2 12'h13c
`define CTPO_ADDR_PERIOD_CH3 12'h16c
`define CTPO_ADDR_PERIOD_CH4 12'h19c
`define CTPO_ADDR_COOL_CH1 12'h1c6
`define CTPO_ADDR_COOL_CH2 12'h1cb
`define CTPO_ADDR_COOL_CH3 12'h1d0
`define CTPO_ADDR_COOL_CH4 12'h1d5
`define CTPO_ADDR_RANGE_CH1 12'h100
`define CTPO_ADDR_RANGE_CH2 12'h130
`define CTPO_ADDR_RANGE_CH3 12'h160
`define CTPO_ADDR_RANGE_CH4 12'h190
`define CTPO_RWR_PV_BASE 5'h08
`define CTPO_RWR_HEAT_BASE 5'h10
`define CTPO_RWR_COOL_BASE 5'h14
`define CTPO_PERIOD_RESET 16'h001e
`define CTPO_CLK_HZ 25000000
`define CTPO_MS_CYCLES (`CTPO_CLK_HZ / 1000)
`define CTPO_SAMPLE_SHORT_MS 250
`define CTPO_SAMPLE_LONG_MS 500
`define CTPO_TENTH_MS 100
`define CTPO_SEC_MS 1000
`define CTPO_PCT_FULL 16'h03e8
`endif

// *** design/ctpo_pkg.sv ***
// Purpose: types for the channel scan and output block
// Assumes: four channels
// Notes: none
package ctpo_pkg;
    typedef logic [1:0] ctpo_chan_type;
    typedef enum {CTPO_IDLE, CTPO_COMPUTE} ctpo_scan_type;
endpackage

// *** design/ctpo_pwm.sv ***
// Purpose: time-proportioned on/off drive for one output
// Assumes: duty in tenths of a percent, 0 to 1000
// Notes: duty and count length taken at each period start; the switch-off compare uses the live period
`timescale 1ns/1ns
`include "ctpo_cfg.svh"
module ctpo_pwm
    import ctpo_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // channel
    ctpo_pwm_if.pwm ch
);
    logic [31:0] cnt_q, cnt_d;
    logic [31:0] on_q, on_d;
    logic drive_q, drive_d;

    always_comb
    begin
        cnt_d = cnt_q;
        on_d = on_q;
        drive_d = drive_q;
        if (ch.ms_tick)
        begin
            if (cnt_q == 32'h0)
            begin
                // new period: latch on-time, output on unless zero (see R12)
                on_d = 32'((64'(ch.period_ms) * 64'(ch.duty_permille)) / 64'(`CTPO_PCT_FULL)); // see R05
                drive_d = (on_d != 32'h0); // see R12
                cnt_d = (ch.period_ms > 32'h1) ? ch.period_ms - 32'h1 : 32'h0; // see R04
            end
            else
            begin
                cnt_d = cnt_q - 32'h1;
                if ((ch.period_ms - cnt_q) >= on_q)
                    drive_d = 1'b0; // see R12
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt_q <= 32'h0;
            on_q <= 32'h0;
            drive_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            on_q <= on_d;
            drive_q <= drive_d;
        end
    end

    assign ch.drive = drive_q;
endmodule

// *** design/ctpo_pwm_if.sv ***
// Purpose: carries one output channel's period and duty to its driver
// Assumes: ms tick from the top
// Notes: none
`timescale 1ns/1ns
interface ctpo_pwm_if;
    logic [31:0] period_ms;
    logic [15:0] duty_permille;
    logic ms_tick;
    logic drive;
    modport ctrl (output period_ms, output duty_permille, output ms_tick, input drive);
    modport pwm (input period_ms, input duty_permille, input ms_tick, output drive);
endinterface

// *** design/ctpo_top.sv ***
// Purpose: channel scan scheduler and time-proportional output stage
// Assumes: master writes words over a simple word port; PID results come from the compute engine
// Notes: PID math is outside; this block schedules it and drives the outputs
`timescale 1ns/1ns
`include "ctpo_cfg.svh"

// Function
// R01 - compute channels in order one to four
// R02 - per-channel restart interval equals sampling cycle
// R03 - cycle length independent of channel use
// R04 - output switches with configured output period
// R05 - on fraction equals manipulated value percent
// R06 - master writes period 1-100 s or 0.5-100.0 s
// R07 - report heating and cooling values per channel
// R08 - heating uses 10CH words, cooling 1C6H words
// R09 - temperature in 1 or 0.1 degree units
// R10 - resistance ranges Pt100 and JPt100 accepted
// R11 - master selects sensor range per channel
// R12 - on at period start, zero stays off
module ctpo_top
    import ctpo_pkg::*;
#(
    // clocks per millisecond tick
    parameter int MS_CYCLES = `CTPO_MS_CYCLES
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // remote buffer memory word port
    input wire logic wr_en,
    input wire logic [11:0] wr_addr,
    input wire logic [15:0] wr_data,
    input wire logic rd_en,
    input wire logic [11:0] rd_addr,
    output logic [15:0] rd_data,
    // cyclic input word port
    input wire logic [4:0] cyc_addr,
    output logic [15:0] cyclic_input_word,
    // compute engine
    output logic compute_start,
    output logic [1:0] compute_chan,
    output logic [15:0] compute_range,
    input wire logic result_valid,
    input wire logic [15:0] result_temp,
    input wire logic [15:0] result_heat,
    input wire logic [15:0] result_cool,
    // transistor outputs
    output logic [3:0] heat_out,
    output logic [3:0] cool_out
);
    logic [15:0] period_q [4], period_d [4];
    logic [15:0] cool_period_q [4], cool_period_d [4];
    logic [15:0] range_q [4], range_d [4];
    logic [15:0] temp_q [4], temp_d [4];
    logic [15:0] heat_q [4], heat_d [4];
    logic [15:0] cool_q [4], cool_d [4];
    logic sample_sel_q, sample_sel_d;
    logic unit_tenth_q, unit_tenth_d;
    logic hc_mode_q, hc_mode_d;
    logic [15:0] rd_data_q, rd_data_d;
    logic [15:0] cyc_q, cyc_d;
    logic [15:0] ms_cnt_q, ms_cnt_d;
    logic ms_tick_q, ms_tick_d;
    logic [15:0] slot_cnt_q, slot_cnt_d;
    ctpo_chan_type chan_q, chan_d;
    logic start_q, start_d;
    logic [15:0] crange_q, crange_d;
    logic [3:0] heat_out_q, cool_out_q;
    logic [3:0] heat_drive, cool_drive;

    // slot length in ms: a quarter of the cycle, remainder spread over the first slots
    // so four slots always add up to the full sampling cycle, whatever is enabled
    function automatic logic [15:0] slot_ms(input logic long_sel, input ctpo_chan_type ch);
        int cyc_ms;
        cyc_ms = long_sel ? `CTPO_SAMPLE_LONG_MS : `CTPO_SAMPLE_SHORT_MS;
        slot_ms = 16'(cyc_ms / 4 + ((int'(ch) < cyc_ms % 4) ? 1 : 0));
    endfunction

    // period word to milliseconds in the selected unit
    function automatic logic [31:0] period_to_ms(input logic [15:0] p, input logic tenth);
        period_to_ms = tenth ? 32'(p) * 32'(`CTPO_TENTH_MS) : 32'(p) * 32'(`CTPO_SEC_MS);
    endfunction

    // registers written by the master
    always_comb
    begin
        sample_sel_d = sample_sel_q;
        unit_tenth_d = unit_tenth_q;
        hc_mode_d = hc_mode_q;
        for (int i = 0; i < 4; i++)
        begin
            period_d[i] = period_q[i];
            cool_period_d[i] = cool_period_q[i];
            range_d[i] = range_q[i];
        end
        if (wr_en)
        begin
            case (wr_addr)
                `CTPO_ADDR_SAMPLE_SEL: sample_sel_d = wr_data[`CTPO_SAMPLE_SEL_BIT]; // see R02
                `CTPO_ADDR_UNIT_SEL: unit_tenth_d = wr_data[0];
                `CTPO_ADDR_HC_SEL: hc_mode_d = wr_data[0];
                `CTPO_ADDR_PERIOD_CH1: period_d[0] = wr_data; // see R06
                `CTPO_ADDR_PERIOD_CH2: period_d[1] = wr_data;
                `CTPO_ADDR_PERIOD_CH3: period_d[2] = wr_data;
                `CTPO_ADDR_PERIOD_CH4: period_d[3] = wr_data;
                `CTPO_ADDR_COOL_CH1: cool_period_d[0] = wr_data; // see R08
                `CTPO_ADDR_COOL_CH2: cool_period_d[1] = wr_data;
                `CTPO_ADDR_COOL_CH3: cool_period_d[2] = wr_data;
                `CTPO_ADDR_COOL_CH4: cool_period_d[3] = wr_data;
                `CTPO_ADDR_RANGE_CH1: range_d[0] = wr_data; // see R11
                `CTPO_ADDR_RANGE_CH2: range_d[1] = wr_data;
                `CTPO_ADDR_RANGE_CH3: range_d[2] = wr_data;
                `CTPO_ADDR_RANGE_CH4: range_d[3] = wr_data;
                default: ;
            endcase
        end
    end

    // read-back of buffer memory words
    always_comb
    begin
        rd_data_d = rd_data_q;
        if (rd_en)
        begin
            case (rd_addr)
                `CTPO_ADDR_SAMPLE_SEL: rd_data_d = 16'(sample_sel_q) << `CTPO_SAMPLE_SEL_BIT;
                `CTPO_ADDR_UNIT_SEL: rd_data_d = {15'h0, unit_tenth_q};
                `CTPO_ADDR_HC_SEL: rd_data_d = {15'h0, hc_mode_q};
                `CTPO_ADDR_PERIOD_CH1: rd_data_d = period_q[0];
                `CTPO_ADDR_PERIOD_CH2: rd_data_d = period_q[1];
                `CTPO_ADDR_PERIOD_CH3: rd_data_d = period_q[2];
                `CTPO_ADDR_PERIOD_CH4: rd_data_d = period_q[3];
                `CTPO_ADDR_COOL_CH1: rd_data_d = cool_period_q[0];
                `CTPO_ADDR_COOL_CH2: rd_data_d = cool_period_q[1];
                `CTPO_ADDR_COOL_CH3: rd_data_d = cool_period_q[2];
                `CTPO_ADDR_COOL_CH4: rd_data_d = cool_period_q[3];
                `CTPO_ADDR_RANGE_CH1: rd_data_d = range_q[0];
                `CTPO_ADDR_RANGE_CH2: rd_data_d = range_q[1];
                `CTPO_ADDR_RANGE_CH3: rd_data_d = range_q[2];
                `CTPO_ADDR_RANGE_CH4: rd_data_d = range_q[3];
                default: rd_data_d = 16'h0;
            endcase
        end
    end

    // millisecond tick and channel rotation
    always_comb
    begin
        ms_cnt_d = ms_cnt_q + 16'h1;
        ms_tick_d = 1'b0;
        slot_cnt_d = slot_cnt_q;
        chan_d = chan_q;
        start_d = 1'b0;
        crange_d = crange_q;
        if (ms_cnt_q == 16'(MS_CYCLES - 1))
        begin
            ms_cnt_d = 16'h0;
            ms_tick_d = 1'b1;
        end
        if (ms_tick_q)
        begin
            if (slot_cnt_q >= slot_ms(sample_sel_q, chan_q) - 16'h1) // see R03
            begin
                slot_cnt_d = 16'h0;
                chan_d = chan_q + 2'h1; // see R01
                start_d = 1'b1; // see R02
                crange_d = range_q[chan_d]; // see R09 R10
            end
            else
                slot_cnt_d = slot_cnt_q + 16'h1;
        end
    end

    // results from the compute engine and cyclic words
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            temp_d[i] = temp_q[i];
            heat_d[i] = heat_q[i];
            cool_d[i] = cool_q[i];
        end
        if (result_valid)
        begin
            temp_d[compute_chan] = result_temp; // see R09
            heat_d[compute_chan] = (result_heat > `CTPO_PCT_FULL) ? `CTPO_PCT_FULL : result_heat;
            cool_d[compute_chan] = (result_cool > `CTPO_PCT_FULL) ? `CTPO_PCT_FULL : result_cool;
        end
        if (cyc_addr[4:2] == 3'(`CTPO_RWR_PV_BASE >> 2))
            cyc_d = temp_q[cyc_addr[1:0]];
        else if (cyc_addr[4:2] == 3'(`CTPO_RWR_HEAT_BASE >> 2))
            cyc_d = heat_q[cyc_addr[1:0]]; // see R07
        else if (cyc_addr[4:2] == 3'(`CTPO_RWR_COOL_BASE >> 2))
            cyc_d = hc_mode_q ? cool_q[cyc_addr[1:0]] : 16'h0; // see R07
        else
            cyc_d = 16'h0;
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < 4; i++)
            begin
                period_q[i] <= `CTPO_PERIOD_RESET;
                cool_period_q[i] <= `CTPO_PERIOD_RESET;
                range_q[i] <= 16'h0;
                temp_q[i] <= 16'h0;
                heat_q[i] <= 16'h0;
                cool_q[i] <= 16'h0;
            end
            sample_sel_q <= 1'b0;
            unit_tenth_q <= 1'b0;
            hc_mode_q <= 1'b0;
            rd_data_q <= 16'h0;
            cyc_q <= 16'h0;
            ms_cnt_q <= 16'h0;
            ms_tick_q <= 1'b0;
            slot_cnt_q <= 16'h0;
            chan_q <= 2'h3;
            start_q <= 1'b0;
            crange_q <= 16'h0;
            heat_out_q <= 4'h0;
            cool_out_q <= 4'h0;
        end
        else
        begin
            period_q <= period_d;
            cool_period_q <= cool_period_d;
            range_q <= range_d;
            temp_q <= temp_d;
            heat_q <= heat_d;
            cool_q <= cool_d;
            sample_sel_q <= sample_sel_d;
            unit_tenth_q <= unit_tenth_d;
            hc_mode_q <= hc_mode_d;
            rd_data_q <= rd_data_d;
            cyc_q <= cyc_d;
            ms_cnt_q <= ms_cnt_d;
            ms_tick_q <= ms_tick_d;
            slot_cnt_q <= slot_cnt_d;
            chan_q <= chan_d;
            start_q <= start_d;
            crange_q <= crange_d;
            heat_out_q <= heat_drive;
            cool_out_q <= hc_mode_q ? cool_drive : 4'h0;
        end
    end

    // one heating and one cooling driver per channel
    for (genvar g = 0; g < 4; g++)
    begin : g_out
        ctpo_pwm_if heat_if ();
        ctpo_pwm_if cool_if ();
        assign heat_if.period_ms = period_to_ms(period_q[g], unit_tenth_q); // see R08
        assign heat_if.duty_permille = heat_q[g];
        assign heat_if.ms_tick = ms_tick_q;
        assign heat_drive[g] = heat_if.drive;
        assign cool_if.period_ms = period_to_ms(cool_period_q[g], unit_tenth_q); // see R08
        assign cool_if.duty_permille = cool_q[g];
        assign cool_if.ms_tick = ms_tick_q;
        assign cool_drive[g] = cool_if.drive;
        ctpo_pwm u_heat (.ref_clk(ref_clk), .nrst(nrst), .ch(heat_if.pwm));
        ctpo_pwm u_cool (.ref_clk(ref_clk), .nrst(nrst), .ch(cool_if.pwm));
    end

    assign rd_data = rd_data_q;
    assign cyclic_input_word = cyc_q;
    assign compute_start = start_q;
    assign compute_chan = chan_q;
    assign compute_range = crange_q;
    assign heat_out = heat_out_q;
    assign cool_out = cool_out_q;
endmodule

// *** verif/ctpo_engine_model.sv ***
// Purpose: compute engine stand-in answering each scan start
// Assumes: per-channel result tables from the bench
// Notes: idle result lines carry inverted data
`timescale 1ns/1ns
module ctpo_engine_model
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // scan request
    input wire logic compute_start,
    input wire logic [1:0] compute_chan,
    input wire logic [15:0] compute_range,
    input wire logic slow,
    input wire logic [3:0][15:0] heat_tab,
    input wire logic [3:0][15:0] cool_tab,
    // results
    output logic result_valid,
    output logic [15:0] result_temp,
    output logic [15:0] result_heat,
    output logic [15:0] result_cool
);
    int wait_q;
    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wait_q <= 0;
            result_valid <= 1'b0;
            {result_temp, result_heat, result_cool} <= '0;
        end
        else
        begin
            result_valid <= wait_q == 1;
            wait_q <= compute_start ? (slow ? 40 : 2) : (wait_q > 0 ? wait_q - 1 : 0);
            if (wait_q == 1)
            begin
                result_temp <= compute_range[0] ? 16'h09c9 : 16'h00fa;
                result_heat <= heat_tab[compute_chan];
                result_cool <= cool_tab[compute_chan];
            end
            else
                {result_temp, result_heat, result_cool} <= ~{result_temp, result_heat, result_cool};
        end
    end
endmodule

// *** verif/ctpo_top_asserts.sv ***
// Purpose: port checks for the scan scheduler and output stage
// Assumes: ms tick length taken from the bound block
// Notes: bound to ctpo_top
`timescale 1ns/1ns
`include "ctpo_cfg.svh"
module ctpo_top_asserts
    import ctpo_pkg::*;
#(
    parameter int MS_CYCLES = `CTPO_MS_CYCLES
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // word ports
    input wire logic wr_en,
    input wire logic [11:0] wr_addr,
    input wire logic [15:0] wr_data,
    input wire logic rd_en,
    input wire logic [11:0] rd_addr,
    input wire logic [15:0] rd_data,
    // scan and outputs
    input wire logic compute_start,
    input wire logic [1:0] compute_chan,
    input wire logic [3:0] cool_out
);
    localparam int SLOT_S = 62 * MS_CYCLES;
    localparam int SLOT_S1 = 63 * MS_CYCLES;
    localparam int SLOT_L = 125 * MS_CYCLES;
    localparam int CYC_S = 250 * MS_CYCLES;
    localparam int CYC_L = 500 * MS_CYCLES;
    int gap_q;
    int cyc_gap_q;
    int cyc_exp;
    logic full_q;
    logic mixed_q;
    logic sel_q;
    logic [1:0] last_q;
    logic seen_q;
    logic hc_q;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            gap_q <= 0;
            last_q <= 2'h3;
            seen_q <= 1'b0;
            hc_q <= 1'b0;
            cyc_gap_q <= 0;
            full_q <= 1'b0;
            mixed_q <= 1'b0;
            sel_q <= 1'b0;
        end
        else
        begin
            gap_q <= compute_start ? 1 : gap_q + 1;
            cyc_gap_q <= (compute_start && compute_chan == 2'h0) ? 1 : cyc_gap_q + 1;
            if (compute_start && compute_chan == 2'h0)
            begin
                full_q <= 1'b1;
                mixed_q <= 1'b0;
            end
            // a cycle that saw a select write is skipped; the write wins over the clear
            if (wr_en && wr_addr == 12'h001)
            begin
                sel_q <= wr_data[12];
                mixed_q <= 1'b1;
            end
            if (compute_start)
            begin
                last_q <= compute_chan;
                seen_q <= 1'b1;
            end
            if (wr_en && wr_addr == 12'h003)
                hc_q <= wr_data[0];
        end
    end
    sequence wr_p1;
        wr_en && wr_addr == 12'h10c;
    endsequence
    sequence wr_c1;
        wr_en && wr_addr == 12'h1c6;
    endsequence
    sequence ch1_start;
        compute_start && compute_chan == 2'h0;
    endsequence
    assign cyc_exp = sel_q ? CYC_L : CYC_S;
    a_start_one_cycle: assert property (compute_start |=> !compute_start)
        else $error("start pulse too long");
    a_chan_rotates: assert property (compute_start |-> compute_chan == last_q + 2'h1)
        else $error("channel out of order");
    a_chan_holds: assert property (!compute_start |-> $stable(compute_chan))
        else $error("channel moved between starts");
    a_slot_length: assert property (compute_start && seen_q |-> (gap_q inside {SLOT_S, SLOT_S1, SLOT_L}))
        else $error("sampling slot length wrong");
    a_cycle_length: assert property (ch1_start ##0 (full_q && !mixed_q) |-> cyc_gap_q == cyc_exp)
        else $error("channel restart interval wrong");
    a_cool_idle: assert property (!hc_q && !$past(hc_q, 4) |-> cool_out == 4'h0)
        else $error("cooling drive outside heating-cooling");
    a_read_holds: assert property (!rd_en |=> $stable(rd_data))
        else $error("read data moved");
    a_heat_rdback: assert property (wr_p1 ##2 (rd_en && rd_addr == 12'h10c) |=> rd_data == $past(wr_data, 3))
        else $error("period word lost");
    a_cool_rdback: assert property (wr_c1 ##2 (rd_en && rd_addr == 12'h1c6) |=> rd_data == $past(wr_data, 3))
        else $error("cooling period word lost");
endmodule
bind ctpo_top ctpo_top_asserts #(.MS_CYCLES(MS_CYCLES)) i_chk (.ref_clk, .nrst, .wr_en, .wr_addr, .wr_data,
    .rd_en, .rd_addr, .rd_data,
    .compute_start, .compute_chan, .cool_out);

// *** verif/ctpo_top_tb_top.sv ***
// Purpose: self-checking bench for the scan scheduler and output stage
// Assumes: 72-cycle ms tick in simulation, run over a few output periods
// Notes: engine stand-in answers each scan start
`timescale 1ns/1ns
`include "ctpo_cfg.svh"
module ctpo_top_tb_top;
    import ctpo_pkg::*;
    // short ms tick keeps the run small; all period writes land before the first tick
    localparam int MS = 72;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic slow = 1'b0;
    logic [11:0] wr_addr = 12'h000;
    logic [11:0] rd_addr = 12'h000;
    logic [15:0] wr_data = 16'h0000;
    logic [4:0] cyc_addr = 5'h00;
    logic [31:0] lfsr = 32'he003;
    logic [3:0][15:0] heat_tab, cool_tab, range_tab;
    logic [15:0] rd_data, cyclic_input_word, compute_range, result_temp, result_heat, result_cool;
    logic [1:0] compute_chan;
    logic compute_start, result_valid;
    logic [3:0] heat_out, cool_out;
    wire [7:0] outs = {cool_out, heat_out};
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;
    int starts = 0;
    int idle_on = 0;
    ctpo_top #(.MS_CYCLES(MS)) i_dut (.ref_clk, .nrst, .wr_en, .wr_addr, .wr_data, .rd_en, .rd_addr, .rd_data,
        .cyc_addr,
        .cyclic_input_word, .compute_start, .compute_chan, .compute_range, .result_valid, .result_temp,
        .result_heat, .result_cool, .heat_out, .cool_out);
    ctpo_engine_model i_eng (.ref_clk, .nrst, .compute_start, .compute_chan, .compute_range, .slow,
        .heat_tab, .cool_tab, .result_valid, .result_temp, .result_heat, .result_cool);
    function automatic logic [15:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr[15:0];
    endfunction
    task automatic conclude();
        if (mismatches == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_near(input int got, input int exp);
        check_count++;
        if (got < exp - 2 || got > exp + 2)
        begin
            mismatches++;
            $display("[ERR] %0t count %0d expected %0d", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        wr_en <= 1'b1;
        wr_addr <= a;
        wr_data <= d;
        @(posedge ref_clk);
        wr_en <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [15:0] exp);
        rd_en <= 1'b1;
        rd_addr <= a;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        @(posedge ref_clk);
        cmp16(rd_data, exp);
    endtask
    task automatic cyc_chk(input logic [4:0] a, input logic [15:0] exp);
        cyc_addr <= a;
        @(posedge ref_clk);
        @(posedge ref_clk);
        cmp16(cyclic_input_word, exp);
    endtask
    task automatic pwm_chk(input int b, input int on_ms, input int per_ms);
        int t0;
        int t1;
        while (outs[b] !== 1'b1)
            @(posedge ref_clk);
        t0 = cycles;
        while (outs[b] !== 1'b0)
            @(posedge ref_clk);
        t1 = cycles;
        while (outs[b] !== 1'b1)
            @(posedge ref_clk);
        cmp_near(t1 - t0, on_ms * MS);
        cmp_near(cycles - t0, per_ms * MS);
    endtask
    initial
    begin
        forever #20 ref_clk = ~ref_clk;
    end
    // scan order model and hang guard
    always @(posedge ref_clk)
    begin
        cycles++;
        if (nrst && heat_out[1] !== 1'b0)
            idle_on++;
        if (compute_start === 1'b1)
        begin
            cmp16({14'h0000, compute_chan}, 16'(starts % 4));
            cmp16(compute_range, range_tab[compute_chan]);
            starts++;
        end
        if (cycles == 95000)
        begin
            mismatches++;
            conclude();
        end
    end
    initial
    begin
        logic [11:0] a;
        logic [15:0] d;
        for (int i = 0; i < 4; i++)
        begin
            heat_tab[i] = rnd() % 16'd1001;
            cool_tab[i] = rnd() % 16'd1200;
            range_tab[i] = rnd();
        end
        heat_tab[0] = 16'd500;
        heat_tab[1] = 16'h0000;
        cool_tab[0] = 16'd300;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        wr(12'h002, 16'h0001);
        wr(12'h003, 16'h0001);
        for (int i = 0; i < 4; i++)
            wr(12'h100 + 12'(i * 'h30), range_tab[i]);
        for (int i = 0; i < 8; i++)
        begin
            a = i < 4 ? 12'h10c + 12'(i * 'h30) : 12'h1c6 + 12'((i - 4) * 5);
            d = rnd();
            wr(a, d);
            rd(a, d);
            wr(a, 16'h0005);
        end
        rd(12'h7ff, 16'h0000);
        while (starts < 6)
            @(posedge ref_clk);
        for (int i = 0; i < 4; i++)
        begin
            d = cool_tab[i] > 16'd1000 ? 16'd1000 : cool_tab[i];
            cyc_chk(5'h10 + 5'(i), heat_tab[i]);
            cyc_chk(5'h14 + 5'(i), d);
            cyc_chk(5'h08 + 5'(i), range_tab[i][0] ? 16'h09c9 : 16'h00fa);
        end
        slow <= 1'b1;
        wr(12'h001, 16'h1000);
        fork
            pwm_chk(0, 250, 500);
            pwm_chk(4, 150, 500);
        join
        while (starts < 12)
            @(posedge ref_clk);
        cmp_near(idle_on, 0);
        conclude();
    end
endmodule
